// file: verilog/usf_defines.vh
// Register map, field positions, reset values and timing counts of the serial status block.
`ifndef USF_DEFINES_VH
`define USF_DEFINES_VH
// ----------------------------------------
// Register word indices (byte offset is four times the index)
// ----------------------------------------
`define USF_OFS_CTRL1 3'h0
`define USF_OFS_CTRL2 3'h1
`define USF_OFS_CTRL3 3'h2
`define USF_OFS_STAT1 3'h3
`define USF_OFS_STAT2 3'h4
`define USF_OFS_DATA 3'h5
`define USF_OFS_BAUD 3'h6
// ----------------------------------------
// Field positions
// ----------------------------------------
`define USF_C1_CHAR9 4
`define USF_C1_WAKE 3
`define USF_C1_PEN 1
`define USF_C1_PODD 0
`define USF_C2_STBY 1
`define USF_C2_SBK 0
`define USF_C2_TXEN 3
`define USF_C2_RXEN 2
`define USF_C3_RB8 7
`define USF_C3_TB8 6
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define USF_CTRL_RST 8'h00
`define USF_BAUD_RST 16'h006B
`define USF_TICKS_PER_BIT 5'h10
`define USF_SLOT_LAST 4'h9
`define USF_IDLE8_TICKS 8'hA0
`define USF_IDLE9_TICKS 8'hB0
`endif

// file: verilog/usf_top.v
// Serial transceiver with status, error flags, break, wakeup and ninth bit.
`timescale 1ns/1ps
`default_nettype none
`include "usf_defines.vh"
module usf_top #(
  parameter [15:0] BAUD_DIV = `USF_BAUD_RST
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Serial line
  input wire rxd,
  output reg txd,
  // Interrupt requests
  output reg tx_irq,
  output reg rx_irq,
  output reg err_irq
);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // Matches an aligned word of the map against one register index.
  function hit;
    input [7:0] adr;
    input [2:0] idx;
    begin
      hit = (adr[7:5] == 3'h0) && (adr[1:0] == 2'h0) && (adr[4:2] == idx);
    end
  endfunction

  wire acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = acc & wb_we_i & wb_sel_i[0];
  wire rd = acc & ~wb_we_i;
  wire wr_c1 = wr & hit(wb_adr_i, `USF_OFS_CTRL1);
  wire wr_c2 = wr & hit(wb_adr_i, `USF_OFS_CTRL2);
  wire wr_c3 = wr & hit(wb_adr_i, `USF_OFS_CTRL3);
  wire wr_dat = wr & hit(wb_adr_i, `USF_OFS_DATA);
  wire wr_baud = wr & hit(wb_adr_i, `USF_OFS_BAUD);
  wire rd_st1 = rd & hit(wb_adr_i, `USF_OFS_STAT1);
  wire rd_st2 = rd & hit(wb_adr_i, `USF_OFS_STAT2);
  wire rd_dat = rd & hit(wb_adr_i, `USF_OFS_DATA);

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  reg [7:0] ctrl1_q;
  reg [7:0] ctrl2_q;
  reg [3:0] err_en_q;
  reg tb8_q;
  reg rb8_q;
  reg [15:0] baud_q;
  reg [7:0] txbuf_q;
  reg [7:0] rxbuf_q;
  wire char9 = ctrl1_q[`USF_C1_CHAR9];
  wire wake_addr = ctrl1_q[`USF_C1_WAKE];
  wire pen = ctrl1_q[`USF_C1_PEN];
  wire podd = ctrl1_q[`USF_C1_PODD];
  wire stby = ctrl2_q[`USF_C2_STBY];
  wire send_break = ctrl2_q[`USF_C2_SBK];
  wire tx_en = ctrl2_q[`USF_C2_TXEN];
  wire rx_en = ctrl2_q[`USF_C2_RXEN];
  wire [3:0] frame_len = char9 ? 4'hB : 4'hA;
  wire [3:0] stop_idx = char9 ? 4'hA : 4'h9;

  // ----------------------------------------
  // Oversampling tick, sixteen per bit
  // ----------------------------------------
  reg [15:0] div_q;
  wire tick = (div_q == 16'h0000);
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 16'h0000;
    end else if (tick) begin
      div_q <= baud_q;
    end else begin
      div_q <= div_q - 16'h0001;
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  reg rx_st_q;
  reg [3:0] rx_sub_q;
  reg [3:0] rx_bit_q;
  reg [1:0] rx_smp_q;
  reg [8:0] rx_sh_q;
  reg rx_nz_q;
  reg [7:0] ones_q;
  reg rpf_q;
  reg brk_ok_q;
  reg bkf_q;
  reg bkf_arm_q;
  reg idle_ok_q;
  wire [2:0] trio = {rx_smp_q, rxd};
  wire maj = (trio[0] & trio[1]) | (trio[0] & trio[2]) | (trio[1] & trio[2]);
  wire noisy = ~(&trio) & (|trio);
  wire slot = tick & rx_st_q & (rx_sub_q == `USF_SLOT_LAST);
  wire false_start = slot & (rx_bit_q == 4'h0) & maj;
  wire rx_done = slot & (rx_bit_q == stop_idx);
  wire [7:0] idle_ticks = char9 ? `USF_IDLE9_TICKS : `USF_IDLE8_TICKS;
  wire idle_ev = tick & ~rx_st_q & rxd & (ones_q == idle_ticks - 8'h01);
  wire top_bit = char9 ? rx_sh_q[8] : rx_sh_q[7];
  wire is_brk = ~maj & (char9 ? (rx_sh_q == 9'h000) : (rx_sh_q[7:0] == 8'h00));
  wire par_bad = pen & ((char9 ? ^rx_sh_q : ^rx_sh_q[7:0]) != podd);
  // Only a finished character may wake by address mark; a stale top bit in the shifter must not.
  wire addr_wake = rx_done & stby & wake_addr & top_bit;
  wire idle_wake = stby & ~wake_addr & idle_ev;
  wire take = rx_done & (~stby | addr_wake);
  wire [5:0] rxf_q;
  wire load = take & ~rxf_q[5];
  wire ovr = take & rxf_q[5];

  // Bit sampling: three samples around mid bit, majority vote, start check.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_st_q <= 1'b0;
      rx_sub_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_smp_q <= 2'h0;
      rx_sh_q <= 9'h000;
      rx_nz_q <= 1'b0;
      ones_q <= 8'h00;
      rpf_q <= 1'b0;
      brk_ok_q <= 1'b1;
    end else if (!rx_en) begin
      rx_st_q <= 1'b0;
      ones_q <= 8'h00;
      rpf_q <= 1'b0;
    end else if (tick) begin
      if (!rx_st_q) begin
        if (!rxd) begin
          rx_st_q <= 1'b1;
          rx_sub_q <= 4'h1;
          rx_bit_q <= 4'h0;
          rx_nz_q <= 1'b0;
          rpf_q <= 1'b1;
          ones_q <= 8'h00;
        end else begin
          brk_ok_q <= 1'b1;
          if (idle_ev) begin
            rpf_q <= 1'b0;
          end
          if (ones_q != idle_ticks) begin
            ones_q <= ones_q + 8'h01;
          end
        end
      end else begin
        rx_sub_q <= rx_sub_q + 4'h1;
        rx_smp_q <= {rx_smp_q[0], rxd};
        if (rx_sub_q == 4'hF) begin
          rx_bit_q <= rx_bit_q + 4'h1;
        end
        if (slot) begin
          rx_nz_q <= rx_nz_q | noisy;
          if (false_start) begin
            rx_st_q <= 1'b0;
            rpf_q <= 1'b0;
          end else if (rx_done) begin
            rx_st_q <= 1'b0;
            rpf_q <= 1'b0;
            if (load & is_brk & brk_ok_q) begin
              brk_ok_q <= 1'b0;
            end
          end else if (rx_bit_q != 4'h0) begin
            rx_sh_q[rx_bit_q - 4'h1] <= maj;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Receive flags and their clearing sequence
  // ----------------------------------------
  // Order: full, idle, overrun, noise, framing, parity.
  wire [5:0] rx_set;
  assign rx_set[5] = load;
  assign rx_set[4] = idle_ev & idle_ok_q & ~stby;
  assign rx_set[3] = ovr;
  assign rx_set[2] = load & (rx_nz_q | noisy);
  assign rx_set[1] = load & ~maj;
  assign rx_set[0] = load & par_bad;
  reg [5:0] flag_q;
  reg [5:0] arm_q;
  wire [5:0] flag_d;
  wire [5:0] arm_d;
  assign rxf_q = flag_q;
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_flag
      // Arming needs the flag set at the status read; a set in the clearing cycle wins.
      assign flag_d[g] = rx_set[g] | (flag_q[g] & ~(rd_dat & arm_q[g]));
      assign arm_d[g] = ~rd_dat & (arm_q[g] | (rd_st1 & flag_q[g]));
    end
  endgenerate

  // Flag storage, arming, break flag and idle permission.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_q <= 6'h00;
      arm_q <= 6'h00;
      bkf_q <= 1'b0;
      bkf_arm_q <= 1'b0;
      idle_ok_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      arm_q <= arm_d;
      if (load & is_brk & brk_ok_q) begin
        bkf_q <= 1'b1;
      end else if (rd_dat & bkf_arm_q) begin
        bkf_q <= 1'b0;
      end
      bkf_arm_q <= ~rd_dat & (bkf_arm_q | (rd_st2 & bkf_q));
      if (load) begin
        idle_ok_q <= 1'b1;
      end else if ((flag_q[4] & ~flag_d[4]) | (wr_c2 & wb_dat_i[`USF_C2_RXEN] & ~rx_en)) begin
        idle_ok_q <= 1'b0;
      end
    end
  end

  // Data buffer and ninth bit keep their value through reset.
  always @(posedge sys_clk) begin
    if (load) begin
      rxbuf_q <= rx_sh_q[7:0];
      rb8_q <= char9 ? (rx_sh_q[8] & ~is_brk) : rx_sh_q[7];
    end
    if (wr_dat) begin
      txbuf_q <= wb_dat_i[7:0];
    end
    if (wr_c3) begin
      tb8_q <= wb_dat_i[`USF_C3_TB8];
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  reg [10:0] tx_sh_q;
  reg [3:0] tx_left_q;
  reg [3:0] tx_sub_q;
  reg pre_q;
  reg brk_pend_q;
  reg brk_run_q;
  reg te_q;
  reg te_arm_q;
  reg tc_q;
  wire tx_idle = (tx_left_q == 4'h0);
  wire brk_req = send_break | brk_pend_q;
  wire [8:0] tdat = {tb8_q, txbuf_q};
  wire par_bit = podd ^ (char9 ? ^tdat[7:0] : ^tdat[6:0]);
  wire b8 = char9 ? (pen ? par_bit : tdat[8]) : 1'b1;
  wire b7 = (~char9 & pen) ? par_bit : tdat[7];
  wire [10:0] frame = {1'b1, b8, b7, tdat[6:0], 1'b0};
  wire tx_start = tick & tx_idle & tx_en;
  wire tx_load = tx_start & ~brk_req & ~pre_q & ~te_q;
  wire bit_end = tick & ~tx_idle & (tx_sub_q == 4'hF);

  // Shifter: preamble, break, tail one after break, or data frame.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_sh_q <= 11'h7FF;
      tx_left_q <= 4'h0;
      tx_sub_q <= 4'h0;
      pre_q <= 1'b0;
      brk_pend_q <= 1'b0;
      brk_run_q <= 1'b0;
    end else begin
      if (wr_c2 & wb_dat_i[`USF_C2_TXEN] & ~tx_en) begin
        pre_q <= 1'b1;
      end
      if (wr_c2 & wb_dat_i[`USF_C2_SBK]) begin
        brk_pend_q <= 1'b1;
      end
      if (tx_start) begin
        tx_sub_q <= 4'h0;
        tx_left_q <= frame_len;
        if (brk_req) begin
          tx_sh_q <= 11'h000;
          brk_run_q <= 1'b1;
          brk_pend_q <= 1'b0;
          pre_q <= 1'b0;
        end else if (pre_q) begin
          tx_sh_q <= 11'h7FF;
          pre_q <= 1'b0;
        end else if (!te_q) begin
          tx_sh_q <= frame;
        end else begin
          tx_left_q <= 4'h0;
        end
      end else if (bit_end & (tx_left_q == 4'h1) & brk_run_q) begin
        tx_sub_q <= 4'h0;
        if (brk_req) begin
          tx_sh_q <= 11'h000;
          tx_left_q <= frame_len;
          brk_pend_q <= 1'b0;
        end else begin
          tx_sh_q <= 11'h7FF;
          tx_left_q <= 4'h1;
          brk_run_q <= 1'b0;
        end
      end else if (bit_end) begin
        tx_sh_q <= {1'b1, tx_sh_q[10:1]};
        tx_left_q <= tx_left_q - 4'h1;
        tx_sub_q <= 4'h0;
      end else if (tick & ~tx_idle) begin
        tx_sub_q <= tx_sub_q + 4'h1;
      end
    end
  end

  // Transmit empty and complete flags.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      te_q <= 1'b1;
      te_arm_q <= 1'b0;
      tc_q <= 1'b1;
    end else begin
      if (tx_load) begin
        te_q <= 1'b1;
      end else if (wr_dat & te_arm_q) begin
        te_q <= 1'b0;
      end
      te_arm_q <= ~wr_dat & (te_arm_q | (rd_st1 & te_q));
      tc_q <= te_q & ~(wr_dat & te_arm_q) & tx_idle & ~pre_q & ~brk_req;
    end
  end

  // ----------------------------------------
  // Software registers and bus answer
  // ----------------------------------------
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl1_q <= `USF_CTRL_RST;
      ctrl2_q <= `USF_CTRL_RST;
      err_en_q <= 4'h0;
      baud_q <= BAUD_DIV;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= acc;
      if (wr_c1) begin
        ctrl1_q <= wb_dat_i[7:0];
      end
      if (wr_c2) begin
        ctrl2_q <= wb_dat_i[7:0];
      end else if (addr_wake | idle_wake) begin
        ctrl2_q[`USF_C2_STBY] <= 1'b0;
      end
      if (wr_c3) begin
        err_en_q <= wb_dat_i[3:0];
      end
      if (wr_baud) begin
        baud_q <= wb_dat_i[15:0];
      end
      if (rd) begin
        case (wb_adr_i[4:2])
          `USF_OFS_CTRL1: wb_dat_o <= {24'h000000, ctrl1_q};
          `USF_OFS_CTRL2: wb_dat_o <= {24'h000000, ctrl2_q};
          `USF_OFS_CTRL3: wb_dat_o <= {24'h000000, rb8_q, tb8_q, 2'h0, err_en_q};
          `USF_OFS_STAT1: wb_dat_o <= {24'h000000, te_q, tc_q, flag_q};
          `USF_OFS_STAT2: wb_dat_o <= {30'h00000000, bkf_q, rpf_q};
          `USF_OFS_DATA: wb_dat_o <= {24'h000000, rxbuf_q};
          `USF_OFS_BAUD: wb_dat_o <= {16'h0000, baud_q};
          default: wb_dat_o <= 32'h00000000;
        endcase
        if (wb_adr_i[7:5] != 3'h0 || wb_adr_i[1:0] != 2'h0) begin
          wb_dat_o <= 32'h00000000;
        end
      end
    end
  end

  // ----------------------------------------
  // Line output and interrupt requests
  // ----------------------------------------
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      txd <= 1'b1;
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
      err_irq <= 1'b0;
    end else begin
      txd <= tx_idle | tx_sh_q[0];
      tx_irq <= (te_q & ctrl2_q[7]) | (tc_q & ctrl2_q[6]);
      rx_irq <= ~stby & ((flag_q[5] & ctrl2_q[5]) | (flag_q[4] & ctrl2_q[4]));
      err_irq <= ~stby & |(flag_q[3:0] & err_en_q);
    end
  end

endmodule // usf_top
`default_nettype wire

// file: verif/usf_top_assertions.sv
// Port-level checker for the serial status and error flag block.
`timescale 1ns/1ps
`default_nettype none
module usf_top_assertions (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Line and requests
  input wire logic rxd,
  input wire logic txd,
  input wire logic tx_irq,
  input wire logic rx_irq,
  input wire logic err_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic take;
  logic [7:0] c2_q;
  logic [3:0] ce_q;
  // A request is taken on an edge where it is raised and not yet answered.
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Shadows of the enable registers as software wrote them.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      c2_q <= 8'h00;
      ce_q <= 4'h0;
    end else if (take && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == 8'h04) c2_q <= wb_dat_i[7:0];
      if (wb_adr_i == 8'h08) ce_q <= wb_dat_i[3:0];
    end
  end
  ack_after_take_a: assert property (take |=> wb_ack_o)
    else $error("request not answered in one cycle");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  reset_idle_a: assert property ($rose(reset_n) |-> txd && !wb_ack_o && !tx_irq)
    else $error("line or bus not idle after reset");
  unmapped_zero_a: assert property (take && !wb_we_i && wb_adr_i > 8'h18 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  ctrl_read_a: assert property (take && !wb_we_i && wb_adr_i == 8'h04 |=>
    wb_dat_o[7:2] == c2_q[7:2]) else $error("control readback wrong");
  enables_read_a: assert property (take && !wb_we_i && wb_adr_i == 8'h08 |=>
    wb_dat_o[3:0] == ce_q) else $error("error enable readback wrong");
  tx_gate_a: assert property (tx_irq |-> (c2_q & 8'hC0) != 0 || ($past(c2_q) & 8'hC0) != 0)
    else $error("transmit request without enable");
  rx_gate_a: assert property (rx_irq |-> (c2_q & 8'h30) != 0 || ($past(c2_q) & 8'h30) != 0)
    else $error("receive request without enable");
  err_gate_a: assert property (err_irq |-> ce_q != 0 || $past(ce_q) != 0)
    else $error("error request without enable");
  cover property ($rose(err_irq));
  cover property ($rose(rx_irq));
  cover property ($fell(txd));
endmodule // usf_top_assertions
bind usf_top usf_top_assertions u_usf_top_assertions (.sys_clk(sys_clk), .reset_n(reset_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .rxd(rxd), .txd(txd), .tx_irq(tx_irq), .rx_irq(rx_irq), .err_irq(err_irq));
`default_nettype wire

// file: verif/usf_line_partner.sv
// Model of the remote transceiver on the serial line.
`timescale 1ns/1ps
`default_nettype none
module usf_line_partner #(
  parameter int BIT_CLKS = 16
) (
  // Clock and line
  input wire logic sys_clk,
  input wire logic txd,
  output logic rxd
);
  // The line idles high, as its pull-up leaves it.
  initial rxd = 1'b1;
  // Sends bits least significant first, then releases the line high.
  task automatic send(input logic [10:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rxd <= f[i];
      repeat (BIT_CLKS) @(posedge sys_clk);
    end
    rxd <= 1'b1;
  endtask
  // Like send, but inverts the line for one clock in the middle of bit k.
  task automatic send_spike(input logic [10:0] f, input int n, input int k);
    for (int i = 0; i < n; i++) begin
      rxd <= f[i];
      repeat (BIT_CLKS / 2) @(posedge sys_clk);
      if (i == k) rxd <= ~f[i];
      @(posedge sys_clk);
      rxd <= f[i];
      repeat (BIT_CLKS / 2 - 1) @(posedge sys_clk);
    end
    rxd <= 1'b1;
  endtask
  // Waits for a start bit and samples nb data bits at their middles.
  task automatic grab(output logic [8:0] b, input int nb);
    int n;
    n = 0;
    b = 9'h000;
    while (txd !== 1'b0 && n < 4000) begin
      @(posedge sys_clk);
      n++;
    end
    repeat (BIT_CLKS + BIT_CLKS / 2) @(posedge sys_clk);
    for (int i = 0; i < nb; i++) begin
      b[i] = txd;
      repeat (BIT_CLKS) @(posedge sys_clk);
    end
  endtask
endmodule // usf_line_partner
`default_nettype wire

// file: verif/tb_usf_top.sv
// Self-checking testbench for the serial status and error flag block.
`timescale 1ns/1ps
`default_nettype none
module tb_usf_top;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, rxd, txd, tx_irq, rx_irq, err_irq;
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  usf_top #(.BAUD_DIV(16'h0000)) u_usf_top (.sys_clk(sys_clk), .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .rxd(rxd), .txd(txd), .tx_irq(tx_irq), .rx_irq(rx_irq), .err_irq(err_irq));
  usf_line_partner #(.BIT_CLKS(16)) u_usf_line_partner (.sys_clk(sys_clk), .txd(txd),
    .rxd(rxd));
  // A tick every clock gives sixteen clocks per bit.
  always #2.5 sys_clk = ~sys_clk;
  // Free-running cycle count for measuring line timing.
  always @(posedge sys_clk) cyc <= cyc + 1;
  // Compares and reports at once.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // One classic bus cycle, held until ack is sampled high.
  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (n >= 50) chk(8'h00, 8'h01);
  endtask
  // Reads a register and compares the masked bits.
  task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q & m, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic frame(input logic [7:0] d, input logic stop);
    u_usf_line_partner.send({1'b1, stop, d, 1'b0}, 10);
  endtask
  task automatic t_reset;
    rc(8'h0C, 8'hFF, 8'hC0);
    rc(8'h10, 8'h03, 8'h00);
    rc(8'h04, 8'hFF, 8'h00);
    rc(8'h08, 8'h0F, 8'h00);
    rc(8'h40, 8'hFF, 8'h00);
  endtask
  task automatic t_rx;
    wr(8'h04, 8'h04);
    frame(8'hA5, 1'b1);
    rc(8'h0C, 8'h20, 8'h20);
    rc(8'h14, 8'hFF, 8'hA5);
    rc(8'h08, 8'h80, 8'h80);
    rc(8'h0C, 8'h30, 8'h00);
    repeat (200) @(posedge sys_clk);
    rc(8'h0C, 8'h10, 8'h10);
    rc(8'h14, 8'h00, 8'h00);
    repeat (200) @(posedge sys_clk);
    rc(8'h0C, 8'h10, 8'h00);
  endtask
  // An overrun arriving between the two reads of the clearing sequence.
  task automatic t_overrun;
    frame(8'h3C, 1'b1);
    rc(8'h0C, 8'h28, 8'h20);
    frame(8'h5A, 1'b1);
    rc(8'h14, 8'hFF, 8'h3C);
    rc(8'h0C, 8'h08, 8'h08);
    rc(8'h14, 8'h00, 8'h00);
    rc(8'h0C, 8'h08, 8'h00);
  endtask
  task automatic t_standby;
    wr(8'h04, 8'h26);
    frame(8'h11, 1'b1);
    rc(8'h0C, 8'h20, 8'h00);
    chk({7'h0, rx_irq}, 8'h00);
    repeat (200) @(posedge sys_clk);
    rc(8'h04, 8'h02, 8'h00);
    frame(8'h42, 1'b1);
    repeat (2) @(posedge sys_clk);
    chk({7'h0, rx_irq}, 8'h01);
    rc(8'h0C, 8'h20, 8'h20);
    rc(8'h14, 8'hFF, 8'h42);
  endtask
  task automatic t_frame;
    wr(8'h08, 8'h02);
    frame(8'h55, 1'b0);
    rc(8'h0C, 8'h22, 8'h22);
    chk({7'h0, err_irq}, 8'h01);
    rc(8'h14, 8'hFF, 8'h55);
    rc(8'h0C, 8'h02, 8'h00);
    chk({7'h0, err_irq}, 8'h00);
  endtask
  task automatic t_break;
    u_usf_line_partner.send(11'h000, 10);
    rc(8'h10, 8'h02, 8'h02);
    rc(8'h0C, 8'h22, 8'h22);
    rc(8'h14, 8'hFF, 8'h00);
    rc(8'h10, 8'h02, 8'h00);
  endtask
  // Preamble, one character out, then both transmit flags back.
  task automatic t_tx;
    logic [8:0] b;
    wr(8'h04, 8'h0C);
    rc(8'h0C, 8'hC0, 8'h80);
    wr(8'h14, 8'h96);
    u_usf_line_partner.grab(b, 8);
    chk(b[7:0], 8'h96);
    rc(8'h0C, 8'h40, 8'h00);
    repeat (40) @(posedge sys_clk);
    rc(8'h0C, 8'hC0, 8'hC0);
    wr(8'h04, 8'h8C);
    repeat (2) @(posedge sys_clk);
    chk({7'h0, tx_irq}, 8'h01);
  endtask
  // Break held over two characters, then released: ends on a character edge with a one.
  task automatic t_brk_tx;
    int t0, n;
    wr(8'h04, 8'h0D);
    n = 0;
    while (txd !== 1'b0 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    t0 = cyc;
    n = 0;
    repeat (330) begin
      @(posedge sys_clk);
      if (txd !== 1'b0) n++;
    end
    chk(8'(n != 0), 8'h00);
    wr(8'h04, 8'h0C);
    while (txd === 1'b0 && cyc - t0 < 700) @(posedge sys_clk);
    chk({7'h0, txd}, 8'h01);
    chk(8'((cyc - t0) % 160), 8'h00);
    chk(8'(cyc - t0 >= 320), 8'h01);
    repeat (20) @(posedge sys_clk);
    rc(8'h0C, 8'h40, 8'h40);
  endtask
  // A one-clock spike mid-bit flags noise; activity shows while the frame runs.
  task automatic t_spike;
    wr(8'h08, 8'h04);
    fork
      u_usf_line_partner.send_spike({1'b1, 1'b1, 8'h5A, 1'b0}, 10, 3);
      begin
        repeat (40) @(posedge sys_clk);
        rc(8'h10, 8'h01, 8'h01);
      end
    join
    rc(8'h0C, 8'h27, 8'h24);
    chk({7'h0, err_irq}, 8'h01);
    rc(8'h14, 8'hFF, 8'h5A);
    rc(8'h0C, 8'h04, 8'h00);
    rc(8'h10, 8'h01, 8'h00);
  endtask
  // Even parity on eight bits with an odd count of ones.
  task automatic t_parity;
    wr(8'h00, 8'h02);
    wr(8'h08, 8'h01);
    frame(8'h83, 1'b1);
    rc(8'h0C, 8'h27, 8'h21);
    chk({7'h0, err_irq}, 8'h01);
    rc(8'h14, 8'hFF, 8'h83);
    rc(8'h0C, 8'h01, 8'h00);
  endtask
  // Address-mark wakeup; the stale top bit of the last character must not wake.
  task automatic t_wake;
    wr(8'h00, 8'h08);
    wr(8'h04, 8'h0E);
    frame(8'h05, 1'b1);
    rc(8'h04, 8'h02, 8'h02);
    rc(8'h0C, 8'h20, 8'h00);
    frame(8'h85, 1'b1);
    rc(8'h04, 8'h02, 8'h00);
    rc(8'h0C, 8'h20, 8'h20);
    rc(8'h14, 8'hFF, 8'h85);
  endtask
  // Nine-bit characters in both directions.
  task automatic t_nine;
    logic [8:0] b;
    wr(8'h00, 8'h10);
    u_usf_line_partner.send({1'b1, 1'b1, 8'h01, 1'b0}, 11);
    rc(8'h08, 8'h80, 8'h80);
    rc(8'h0C, 8'h20, 8'h20);
    rc(8'h14, 8'hFF, 8'h01);
    rc(8'h0C, 8'h80, 8'h80);
    wr(8'h08, 8'h40);
    wr(8'h14, 8'h3C);
    u_usf_line_partner.grab(b, 9);
    chk(b[7:0], 8'h3C);
    chk({7'h0, b[8]}, 8'h01);
  endtask
  // Reset in mid-run: controls and flags return, ninth bits keep their value.
  task automatic t_midreset;
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    rc(8'h08, 8'hCF, 8'hC0);
    rc(8'h0C, 8'hFF, 8'hC0);
    rc(8'h04, 8'hFF, 8'h00);
    rc(8'h10, 8'h03, 8'h00);
  endtask
  task automatic complete_run;
    if (miscompares == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Main sequence after reset.
  initial begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset;
    t_rx;
    t_overrun;
    t_standby;
    t_frame;
    t_break;
    t_tx;
    t_brk_tx;
    t_spike;
    t_parity;
    t_wake;
    t_nine;
    t_midreset;
    complete_run;
  end
  // Watchdog well beyond the expected few thousand cycles.
  initial begin
    repeat (30000) @(posedge sys_clk);
    miscompares++;
    complete_run;
  end
endmodule // tb_usf_top
`default_nettype wire
